// File: rtl/lec_regs.sv
// Link security configuration and interrupt enable registers behind an APB slave.
//
// Overview of operation
// - Verify bit set: check link value every 16th frame.
// - Config bit 5 turns repeater mode on.
// - Bits 4:3 choose the frame encryption policy.
// - Strap set gives mode 11, else 00.
// - Detect select 1 also needs receiver lock.
// - Enable bit 7 gates indirect access interrupt.
// - Enable bit 6 gates receiver detect interrupt.
// - Enable bit 5 passes downstream interrupt requests.
// - Bit 0 globally gates the host interrupt.
// - Global flag shows any enabled pending source.
`timescale 1ns/100ps
`default_nettype none
module lec_regs
  import lec_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,

  // APB slave
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_DW-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,

  // Straps and frame timing
  input  wire logic              repeater_strap,
  input  wire logic              frame_start,
  input  wire logic              frame_inband_encrypt,
  input  wire logic              link_authenticated,
  input  wire logic              reg_encrypt_request,

  // Downstream receiver and indirect access events
  input  wire logic              rx_detected,
  input  wire logic              rx_locked,
  input  wire logic              remote_irq_req,
  input  wire logic              indirect_access_done,

  // Link control outputs
  output logic                   link_check_strobe,
  output logic                   repeater_enable,
  output lec_enc_mode_t          enc_mode,
  output logic                   encrypt_frame,

  // Host interrupt
  output logic                   irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Reserved bits are dropped on the way in, so they always read back as zero.
  function automatic logic [7:0] lec_wr_byte(input logic [APB_DW-1:0] wdata, input logic [7:0] wmask);
    lec_wr_byte = wdata[7:0] & wmask;
  endfunction

  // An eight-bit register sits in the low byte of the bus word with the upper bits zero.
  function automatic logic [APB_DW-1:0] lec_rd_word(input logic [7:0] value);
    lec_rd_word = {{(APB_DW-8){1'b0}}, value};
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic sel_cfg;
  logic sel_en;
  logic sel_stat;
  logic sel_link;
  logic addr_hit;
  logic setup_ph;
  logic wr_take;
  logic wr_lane0;

  always_comb begin
    sel_cfg  = (paddr == lec_addr(IDX_SEC_CFG));
    sel_en   = (paddr == lec_addr(IDX_IRQ_EN));
    sel_stat = (paddr == lec_addr(IDX_IRQ_STAT));
    sel_link = (paddr == lec_addr(IDX_LINK_STAT));
    addr_hit = sel_cfg | sel_en | sel_stat | sel_link;
    setup_ph = psel & ~penable;
    // The write lands on the single edge where the master sees pready high.
    wr_take  = psel & penable & pready & pwrite & addr_hit;
    wr_lane0 = wr_take & pstrb[0];
  end

  // ****************************************************************
  // Strap capture after reset release
  // ****************************************************************
  logic strap_done_q;
  logic strap_done_d;
  logic strap_val_q;
  logic strap_val_d;
  logic strap_load;

  // The strap is read by the clock one cycle after release, never by the reset itself.
  always_comb begin
    strap_load   = ~strap_done_q;
    strap_done_d = 1'b1;
    strap_val_d  = strap_load ? repeater_strap : strap_val_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_done_q <= 1'b0;
      strap_val_q  <= 1'b0;
    end else if (ce) begin
      strap_done_q <= strap_done_d;
      strap_val_q  <= strap_val_d;
    end
  end

  // ****************************************************************
  // Security configuration register
  // ****************************************************************
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (strap_load) begin
      cfg_d[CFG_MODE_HI:CFG_MODE_LO] = repeater_strap ? ENC_FRAME : ENC_AUTH;
    end
    if (wr_lane0 && sel_cfg) begin
      cfg_d = lec_wr_byte(pwdata, CFG_WMASK);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= CFG_RESET;
    end else if (ce) begin
      cfg_q <= cfg_d;
    end
  end

  // ****************************************************************
  // Interrupt enable register
  // ****************************************************************
  // This register doubles as the interrupt mask; a cleared bit still lets its status bit set.
  logic [7:0] en_q;
  logic [7:0] en_d;

  always_comb begin
    en_d = en_q;
    if (wr_lane0 && sel_en) begin
      en_d = lec_wr_byte(pwdata, IRQ_WMASK);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_q <= IRQ_RESET;
    end else if (ce) begin
      en_q <= en_d;
    end
  end

  // ****************************************************************
  // Event qualification
  // ****************************************************************
  logic                 det_qual;
  logic                 det_qual_q;
  logic                 det_rise;
  logic [IRQ_SRC_N-1:0] ev_set;
  logic [IRQ_SRC_N-1:0] ev_clr;
  logic [IRQ_SRC_N-1:0] stat;

  // A detect counts once per rising edge of the qualified level, so a receiver that stays
  // present does not refire after software clears the bit.
  always_comb begin
    det_qual = rx_detected & (~cfg_q[CFG_LOCK_BIT] | rx_locked);
    det_rise = det_qual & ~det_qual_q;
    ev_set   = {indirect_access_done, det_rise, remote_irq_req};
    ev_clr   = '0;
    if (wr_lane0 && sel_stat) begin
      ev_clr = pwdata[IRQ_IND_BIT:IRQ_REM_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      det_qual_q <= 1'b0;
    end else if (ce) begin
      det_qual_q <= det_qual;
    end
  end

  // Inside the sticky bank a set beats a clear in the same cycle, so no event is lost.
  lec_sticky u_sticky (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .set_i   (ev_set),
    .clr_i   (ev_clr),
    .stat_q  (stat)
  );

  // ****************************************************************
  // Interrupt combine
  // ****************************************************************
  logic [IRQ_SRC_N-1:0] pending;
  logic                 global_flag;
  logic                 irq_d;

  always_comb begin
    pending[2]  = stat[2] & en_q[IRQ_IND_BIT];
    pending[1]  = stat[1] & en_q[IRQ_DET_BIT];
    pending[0]  = stat[0] & en_q[IRQ_REM_BIT];
    // The global flag ignores the global enable, so software can poll with the line switched off.
    global_flag = |pending;
    irq_d       = en_q[IRQ_GLOBAL_BIT] & global_flag;
  end

  // ****************************************************************
  // Periodic link check
  // ****************************************************************
  logic check_q;

  // The check request is registered once more on its way out, so the strobe trails the frame by two edges.
  lec_frame_check u_frame_check (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .ce          (ce),
    .enable      (cfg_q[CFG_VERIFY_BIT]),
    .frame_start (frame_start),
    .check_q     (check_q)
  );

  // ****************************************************************
  // Encryption policy
  // ****************************************************************
  lec_enc_mode_t mode_cur;
  logic          enc_d;

  // The policy result is registered together with the mode, so both outputs change on the same edge.
  always_comb begin
    mode_cur = lec_enc_mode_t'(cfg_q[CFG_MODE_HI:CFG_MODE_LO]);
    unique case (mode_cur)
      ENC_AUTH:   enc_d = link_authenticated;
      ENC_REG:    enc_d = reg_encrypt_request;
      ENC_ALWAYS: enc_d = 1'b1;
      ENC_FRAME:  enc_d = frame_inband_encrypt;
    endcase
  end

  // ****************************************************************
  // Read path and bus answer
  // ****************************************************************
  logic [APB_DW-1:0] rdata_d;
  logic              ready_d;
  logic              err_d;

  // Read data is captured in the setup cycle so that the answer comes from a flop with no wait.
  always_comb begin
    rdata_d = prdata;
    ready_d = setup_ph;
    // An unmapped address is answered at once with an error and zero data, and a write to it is dropped.
    err_d   = setup_ph & ~addr_hit;
    if (setup_ph) begin
      rdata_d = '0;
      if (sel_cfg) begin
        rdata_d = lec_rd_word(cfg_q);
      end
      if (sel_en) begin
        rdata_d = lec_rd_word(en_q);
      end
      if (sel_stat) begin
        rdata_d[IRQ_IND_BIT:IRQ_REM_BIT] = stat;
        rdata_d[IRQ_GLOBAL_BIT]          = global_flag;
      end
      if (sel_link) begin
        rdata_d[3:0] = {det_qual, strap_val_q, rx_locked, rx_detected};
      end
    end
  end

  // ****************************************************************
  // Bus answer registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata  <= rdata_d;
      pready  <= ready_d;
      pslverr <= err_d;
    end
  end

  // ****************************************************************
  // Link control output registers
  // ****************************************************************
  logic          strobe_d;
  logic          rpt_d;
  lec_enc_mode_t mode_d;

  // Every link control output leaves from a flop, so the pins never show decode glitches.
  always_comb begin
    strobe_d = check_q;
    rpt_d    = cfg_q[CFG_RPT_BIT];
    mode_d   = mode_cur;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_check_strobe <= 1'b0;
      repeater_enable   <= 1'b0;
      enc_mode          <= ENC_AUTH;
      encrypt_frame     <= 1'b0;
    end else if (ce) begin
      link_check_strobe <= strobe_d;
      repeater_enable   <= rpt_d;
      enc_mode          <= mode_d;
      encrypt_frame     <= enc_d;
    end
  end

  // ****************************************************************
  // Host interrupt register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= irq_d;
    end
  end

endmodule
`default_nettype wire

// File: rtl/lec_pkg.sv
// Package of constants and types for the link security configuration and interrupt enable block.
`default_nettype none
package lec_pkg;

  // ****************************************************************
  // Register bus geometry and register indices
  // ****************************************************************
  localparam int unsigned APB_AW         = 12;
  localparam int unsigned APB_DW         = 32;
  localparam logic [7:0]  IDX_SEC_CFG    = 8'hC2;
  localparam logic [7:0]  IDX_IRQ_EN     = 8'hC6;
  localparam logic [7:0]  IDX_IRQ_STAT   = 8'hC7;
  localparam logic [7:0]  IDX_LINK_STAT  = 8'hD0;

  // ****************************************************************
  // Security configuration fields
  // ****************************************************************
  localparam int unsigned CFG_VERIFY_BIT = 7;
  localparam int unsigned CFG_RPT_BIT    = 5;
  localparam int unsigned CFG_MODE_HI    = 4;
  localparam int unsigned CFG_MODE_LO    = 3;
  localparam int unsigned CFG_LOCK_BIT   = 1;
  localparam logic [7:0]  CFG_RESET      = 8'h80;
  localparam logic [7:0]  CFG_WMASK      = 8'hBA;

  // ****************************************************************
  // Interrupt enable and status fields
  // ****************************************************************
  localparam int unsigned IRQ_IND_BIT    = 7;
  localparam int unsigned IRQ_DET_BIT    = 6;
  localparam int unsigned IRQ_REM_BIT    = 5;
  localparam int unsigned IRQ_GLOBAL_BIT = 0;
  localparam int unsigned IRQ_SRC_N      = 3;
  localparam logic [7:0]  IRQ_RESET      = 8'h00;
  localparam logic [7:0]  IRQ_WMASK      = 8'hE1;
  localparam logic [2:0]  STAT_RESET     = 3'h0;

  // ****************************************************************
  // Periodic link check
  // ****************************************************************
  localparam int unsigned VERIFY_PERIOD  = 16;
  localparam int unsigned FRAME_CNT_W    = $clog2(VERIFY_PERIOD);
  localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_LAST = FRAME_CNT_W'(VERIFY_PERIOD - 1);

  // ****************************************************************
  // Encryption policy
  // ****************************************************************
  typedef enum logic [1:0] {
    ENC_AUTH   = 2'h0,
    ENC_REG    = 2'h1,
    ENC_ALWAYS = 2'h2,
    ENC_FRAME  = 2'h3
  } lec_enc_mode_t;

  // Byte address of a register word from its index.
  function automatic logic [APB_AW-1:0] lec_addr(input logic [7:0] idx);
    lec_addr = {2'h0, idx, 2'h0};
  endfunction

endpackage
`default_nettype wire

// File: rtl/lec_sticky.sv
// Sticky event bits, set by hardware and cleared by software.
`timescale 1ns/100ps
`default_nettype none
module lec_sticky
  import lec_pkg::*;
(
  // Clock and control
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 ce,
  // Events and clears
  input  wire logic [IRQ_SRC_N-1:0] set_i,
  input  wire logic [IRQ_SRC_N-1:0] clr_i,
  // State
  output logic      [IRQ_SRC_N-1:0] stat_q
);

  logic [IRQ_SRC_N-1:0] stat_d;

  // An event in the cycle of its clear is kept, so the set is applied last.
  always_comb begin
    stat_d = (stat_q & ~clr_i) | set_i;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_q <= STAT_RESET;
    end else if (ce) begin
      stat_q <= stat_d;
    end
  end

endmodule
`default_nettype wire

// File: rtl/lec_frame_check.sv
// Frame counter that requests a link check value comparison every period of frames.
`timescale 1ns/100ps
`default_nettype none
module lec_frame_check
  import lec_pkg::*;
(
  // Clock and control
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  // Frame side
  input  wire logic enable,
  input  wire logic frame_start,
  // Check request
  output logic      check_q
);

  logic [FRAME_CNT_W-1:0] cnt_q;
  logic [FRAME_CNT_W-1:0] cnt_d;
  logic                   check_d;

  // Turning the check off restarts the count, so the first check after enabling is a full period away.
  always_comb begin
    cnt_d   = cnt_q;
    check_d = 1'b0;
    if (!enable) begin
      cnt_d = '0;
    end else if (frame_start) begin
      cnt_d   = cnt_q + 1'b1;
      check_d = (cnt_q == FRAME_CNT_LAST);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q   <= '0;
      check_q <= 1'b0;
    end else if (ce) begin
      cnt_q   <= cnt_d;
      check_q <= check_d;
    end
  end

endmodule
`default_nettype wire

// File: sim/lec_props.sv
// Assertion checker for the link security and interrupt enable registers.
`timescale 1ns/100ps
`default_nettype none
module lec_props
  import lec_pkg::*;
(
  // Clock and bus
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              ce,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Frame side and outputs
  input wire logic              frame_start,
  input wire logic              frame_inband_encrypt,
  input wire logic              link_check_strobe,
  input wire logic              repeater_enable,
  input wire lec_enc_mode_t     enc_mode,
  input wire logic              encrypt_frame,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic wr_ok  = psel && penable && pready && pwrite && pstrb[0] && ce;
  wire logic wr_cfg = wr_ok && paddr == 12'h308;
  wire logic wr_en  = wr_ok && paddr == 12'h318;
  wire logic mapped = paddr inside {12'h308, 12'h318, 12'h31C, 12'h340};

  ready_pulse_a:
    assert property (psel && !penable && ce |=> pready) else $error("no answer after setup");
  ready_once_a:
    assert property (pready |=> !pready) else $error("ready stands too long");
  err_map_a:
    assert property (pready && !mapped |-> pslverr && prdata == '0) else $error("unmapped access not refused");
  rpt_copy_a:
    assert property (wr_cfg |=> ##1 repeater_enable == $past(pwdata[5], 2)) else $error("repeater bit not applied");
  mode_copy_a:
    assert property (wr_cfg |=> ##1 enc_mode == $past(pwdata[4:3], 2)) else $error("mode field not applied");
  enc_always_a:
    assert property (enc_mode == ENC_ALWAYS |-> encrypt_frame) else $error("always mode not encrypting");
  enc_frame_a:
    assert property (enc_mode == ENC_FRAME && $past(ce) |-> encrypt_frame == $past(frame_inband_encrypt))
      else $error("per frame mode wrong");
  strobe_src_a:
    assert property (link_check_strobe |-> $past(frame_start, 2)) else $error("check strobe without frame");
  irq_off_a:
    assert property (wr_en && !pwdata[0] |=> ##1 !irq) else $error("irq with global enable off");
endmodule
bind lec_regs lec_props u_props (.clk(clk), .sys_rst(sys_rst), .ce(ce), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .frame_start(frame_start), .frame_inband_encrypt(frame_inband_encrypt),
  .link_check_strobe(link_check_strobe), .repeater_enable(repeater_enable), .enc_mode(enc_mode),
  .encrypt_frame(encrypt_frame), .irq(irq));
`default_nettype wire

// File: sim/lec_rx_model.sv
// Behavioural downstream receiver giving detect, lock and remote interrupt levels.
`timescale 1ns/100ps
`default_nettype none
module lec_rx_model (
  // Clock
  input  wire logic clk,
  // Scenario commands
  input  wire logic detect_cmd,
  input  wire logic lock_cmd,
  input  wire logic irq_cmd,
  // Receiver levels
  output logic      rx_detected,
  output logic      rx_locked,
  output logic      remote_irq_req
);
  // A receiver reports lock or requests only while it is present on the link.
  always_ff @(posedge clk) begin
    rx_detected    <= detect_cmd;
    rx_locked      <= detect_cmd && lock_cmd;
    remote_irq_req <= detect_cmd && irq_cmd;
  end
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking testbench for the link security and interrupt enable registers.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb
  import lec_pkg::*;
;
  logic clk = 0, sys_rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, e, link_check_strobe, repeater_enable, encrypt_frame, irq;
  logic repeater_strap = 0, frame_start = 0, frame_inband_encrypt = 0, link_authenticated = 0;
  logic reg_encrypt_request = 0, indirect_access_done = 0, detect_cmd = 0, lock_cmd = 0, irq_cmd = 0;
  logic rx_detected, rx_locked, remote_irq_req;
  lec_enc_mode_t enc_mode;
  int fails = 0, checks_done = 0, strobes = 0;

  lec_regs u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .repeater_strap(repeater_strap), .frame_start(frame_start), .frame_inband_encrypt(frame_inband_encrypt),
    .link_authenticated(link_authenticated), .reg_encrypt_request(reg_encrypt_request),
    .rx_detected(rx_detected), .rx_locked(rx_locked), .remote_irq_req(remote_irq_req),
    .indirect_access_done(indirect_access_done), .link_check_strobe(link_check_strobe),
    .repeater_enable(repeater_enable), .enc_mode(enc_mode), .encrypt_frame(encrypt_frame), .irq(irq));
  lec_rx_model u_rx (.clk(clk), .detect_cmd(detect_cmd), .lock_cmd(lock_cmd), .irq_cmd(irq_cmd),
    .rx_detected(rx_detected), .rx_locked(rx_locked), .remote_irq_req(remote_irq_req));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (link_check_strobe === 1'b1) strobes++;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // The master waits for pready without assuming a latency; an idle cycle separates transfers.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic do_reset(input logic s);
    sys_rst <= 1; repeater_strap <= s;
    cyc(6);
    sys_rst <= 0;
    cyc(3);
  endtask
  task automatic frames(input int n);
    repeat (n) begin frame_start <= 1; @(posedge clk); frame_start <= 0; cyc(3); end
  endtask
  task automatic pulse_ind();
    indirect_access_done <= 1; @(posedge clk); indirect_access_done <= 0; cyc(2);
  endtask

  task automatic t_reset();
    rd(12'h308); `CHK(r, 32'h80)
    rd(12'h318); `CHK(r, 32'h0)
    `CHK(enc_mode, ENC_AUTH)
    do_reset(1);
    `CHK(enc_mode, ENC_FRAME)
    rd(12'h308); `CHK(r, 32'h98)
    do_reset(0);
  endtask
  task automatic t_enc();
    wr(12'h308, 32'hFF); rd(12'h308); `CHK(r, 32'hBA)
    `CHK(repeater_enable, 1'b1)
    for (int m = 0; m < 4; m++) begin
      wr(12'h308, 32'(m) << 3); cyc(1);
      `CHK(repeater_enable, 1'b0)
      `CHK(enc_mode, lec_enc_mode_t'(m))
      link_authenticated <= (m == 0); reg_encrypt_request <= (m == 1); frame_inband_encrypt <= (m == 3);
      cyc(2); `CHK(encrypt_frame, 1'b1)
      link_authenticated <= 0; reg_encrypt_request <= 0; frame_inband_encrypt <= 0;
      cyc(2); `CHK(encrypt_frame, 1'(m == 2))
    end
  endtask
  task automatic t_frame();
    int s;
    wr(12'h308, 32'h0); s = strobes;
    wr(12'h308, 32'h80); frames(15); `CHK(strobes, s)
    frames(1); `CHK(strobes, s + 1)
    frames(16); `CHK(strobes, s + 2)
    wr(12'h308, 32'h0); frames(16); `CHK(strobes, s + 2)
  endtask
  task automatic t_irq();
    wr(12'h318, 32'h0); wr(12'h31C, 32'hE0); pulse_ind();
    rd(12'h31C); `CHK(r, 32'h80)
    wr(12'h318, 32'hE0); rd(12'h31C); `CHK(r, 32'h81)
    `CHK(irq, 1'b0)
    wr(12'h318, 32'hE1); cyc(1); `CHK(irq, 1'b1)
    wr(12'h31C, 32'h80); cyc(1); `CHK(irq, 1'b0)
    wr(12'h308, 32'h02); detect_cmd <= 1; cyc(4);
    rd(12'h31C); `CHK(r, 32'h0)
    lock_cmd <= 1; cyc(4); `CHK(irq, 1'b1)
    rd(12'h31C); `CHK(r, 32'h41)
    wr(12'h318, 32'hA1); cyc(1); `CHK(irq, 1'b0)
    wr(12'h31C, 32'h40); detect_cmd <= 0; lock_cmd <= 0; wr(12'h308, 32'h0);
    detect_cmd <= 1; cyc(4); rd(12'h31C); `CHK(r, 32'h40)
    wr(12'h31C, 32'h40); irq_cmd <= 1; cyc(4); `CHK(irq, 1'b1)
    wr(12'h318, 32'h81); cyc(1); `CHK(irq, 1'b0)
    rd(12'h31C); `CHK(r, 32'h20)
    irq_cmd <= 0; detect_cmd <= 0; cyc(3); wr(12'h31C, 32'h20);
    wr(12'h318, 32'hE1); cyc(1); `CHK(irq, 1'b0)
  endtask
  task automatic t_bus();
    rd(12'h300); `CHK(e, 1'b1)
    `CHK(r, 32'h0)
    wr(12'h300, 32'hFF); `CHK(e, 1'b1)
    apb(1'b1, 12'h318, 32'h00, 4'h0); rd(12'h318); `CHK(r, 32'hE1)
    wr(12'h318, 32'hFF); rd(12'h318); `CHK(r, 32'hE1)
    // With the clock enable low an event pulse is not taken and the line stays quiet.
    ce <= 0; pulse_ind(); ce <= 1; rd(12'h31C); `CHK(r, 32'h0)
    `CHK(irq, 1'b0)
  endtask

  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial begin
    do_reset(0);
    t_reset(); t_enc(); t_frame(); t_irq(); t_bus();
    report_and_stop();
  end
endmodule
`default_nettype wire
